// *** hw/nbx_pkg.sv ***
// ****************************************************************
// Shared constants of the nibble execute unit
// ****************************************************************
`default_nettype none
package nbx_pkg;

  // ****************************************************************
  // Register word addresses (haddr[7:2])
  // ****************************************************************
  localparam logic [5:0] IDX_INSTR = 6'h00;
  localparam logic [5:0] IDX_CORE = 6'h01;
  localparam logic [5:0] IDX_CTRL = 6'h02;
  localparam logic [5:0] IDX_TIMING = 6'h03;
  localparam logic [5:0] IDX_MEM_ADDR = 6'h04;
  localparam logic [5:0] IDX_MEM_DATA = 6'h05;

  // ****************************************************************
  // Instruction fields
  // ****************************************************************
  localparam int OP_HI = 15;
  localparam int OP_LO = 8;
  localparam int IMM_HI = 7;
  localparam int IMM_LO = 4;
  localparam int WR_HI = 3;
  localparam int WR_LO = 0;
  localparam int MA_HI = 6;
  localparam int MA_LO = 0;
  localparam int CALL_HI = 15;
  localparam int CALL_LO = 11;
  localparam logic [4:0] CALL_CODE = 5'h1c;

  // ****************************************************************
  // Opcode byte values
  // ****************************************************************
  localparam logic [7:0] OP_ADC_M = 8'h10;
  localparam logic [7:0] OP_ADC_I = 8'h0c;
  localparam logic [7:0] OP_ADC_STORE = 8'h12;
  localparam logic [7:0] OP_CY_TO_M = 8'h40;
  localparam logic [7:0] OP_M_TO_CY = 8'h41;
  localparam logic [7:0] OP_PARAM_CLR = 8'h42;
  localparam logic [7:0] OP_PARAM_SET = 8'h43;
  localparam logic [7:0] OP_EVENT_CLR = 8'h44;
  localparam logic [7:0] OP_PORT_EN_LD = 8'h45;
  localparam logic [7:0] OP_IRQ_EN_LD = 8'h46;
  localparam logic [7:0] OP_HOLD_EN_LD = 8'h47;
  localparam logic [7:0] OP_WAKE_EN_LD = 8'h48;
  localparam logic [7:0] OP_CLK_CTRL_LD = 8'h49;
  localparam logic [7:0] OP_PSR_RD = 8'h4a;
  localparam logic [7:0] OP_PSR_CLR = 8'h4b;
  localparam logic [7:0] OP_CY_SET = 8'h4c;
  localparam logic [7:0] OP_CY_CLR = 8'h4d;
  localparam logic [7:0] OP_DIV_CLR = 8'h4e;
  localparam logic [7:0] OP_WDT_CLR = 8'h4f;
  localparam logic [7:0] OP_SHR = 8'h50;
  localparam logic [7:0] OP_RRC = 8'h51;
  localparam logic [7:0] OP_SHL = 8'h52;
  localparam logic [7:0] OP_RLC = 8'h53;
  localparam logic [7:0] OP_LAT_I = 8'h54;
  localparam logic [7:0] OP_LAT_RD = 8'h55;
  localparam logic [7:0] OP_LAT_WR = 8'h56;
  localparam logic [7:0] OP_LAT_ACC = 8'h57;
  localparam logic [7:0] OP_DRIVE_MODE_LD = 8'h58;
  localparam logic [7:0] OP_TMA_H = 8'h59;
  localparam logic [7:0] OP_TMA_L = 8'h5a;
  localparam logic [7:0] OP_TMB_H = 8'h5b;
  localparam logic [7:0] OP_TMB_L = 8'h5c;
  localparam logic [7:0] OP_RET = 8'h5d;
  localparam logic [7:0] OP_HOLD = 8'h5e;
  localparam logic [7:0] OP_STOP = 8'h5f;
  localparam logic [7:0] OP_NOP = 8'h60;
  localparam logic [7:0] OP_INT_EN = 8'h61;
  localparam logic [7:0] OP_INT_DIS = 8'h62;

  // ****************************************************************
  // Reset values and widths
  // ****************************************************************
  localparam logic [3:0] RST_NIB = 4'h0;
  localparam logic [10:0] RST_PC = 11'h000;
  localparam logic [2:0] RST_SP = 3'h0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [13:0] RST_DIV = 14'h0000;
  localparam logic [3:0] DIV_LOW_MASK = 4'hf;
  localparam int DIV_W = 14;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

endpackage

`default_nettype wire

// *** hw/nbx_exec.sv ***
`timescale 1ns/10ps
`default_nettype none

// What this block does
// RL1 - ADC memory: mem+acc+carry into acc only
// RL2 - ADC immediate: wr+imm+carry into acc only
// RL3 - Storing add with carry into acc and memory
// RL4 - Clear param flags where immediate bit set
// RL5 - Set param flags where immediate bit set
// RL6 - Clear event flags where immediate bit set
// RL7 - Load hold release enables from immediate
// RL8 - Load stop wake enables from immediate
// RL9 - Load system clock control from immediate
// RL10 - Port status to acc and memory, zero
// RL11 - Clear whole port status register
// RL12 - Clear divider low four bits only
// RL13 - Shift right, zero fill, bit0 to carry
// RL14 - Rotate right through carry
// RL15 - Shift left, zero fill, bit3 to carry
// RL16 - Rotate left through carry
// RL17 - Load display drive mode from immediate
// RL18 - Load timer A preset nibbles from memory
// RL19 - Load timer B preset nibbles from memory
// RL20 - Call pushes next address, loads 11 bits
// RL21 - Carry to bit0, bit0 to carry
// RL22 - Set/clear carry, enable/disable interrupts
// RL23 - Return pops stack; hold and stop entry
// RL24 - Watchdog restart; display latch moves
module nbx_exec #(
  parameter int WDT_W = 18,
  parameter int STACK_DEPTH = 8
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic [1:0] o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic [3:0] i_event_set,
  input wire logic [3:0] i_port_status_set,
  input wire logic [3:0] i_hold_release_src,
  input wire logic [3:0] i_wake_pins,
  output logic o_hold,
  output logic o_stop,
  output logic o_int_en,
  output logic [3:0] o_param_flags,
  output logic [3:0] o_event_flags,
  output logic [3:0] o_port_enables,
  output logic [3:0] o_irq_enables,
  output logic [3:0] o_sys_clock_ctrl,
  output logic [3:0] o_display_mode,
  output logic [3:0] o_display_latch,
  output logic [7:0] o_timer_a_preset,
  output logic [7:0] o_timer_b_preset,
  output logic [10:0] o_pc
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [127:0][3:0] mem;
    logic [STACK_DEPTH-1:0][10:0] stack;
    logic [2:0] sp;
    logic [10:0] pc;
    logic [3:0] acc;
    logic cy;
    logic zf;
    logic ie;
    logic hold;
    logic stop;
    logic [3:0] param_flags;
    logic [3:0] event_flags;
    logic [3:0] port_enable_flags;
    logic [3:0] irq_enable_flags;
    logic [3:0] hold_release_enables;
    logic [3:0] stop_wake_enables;
    logic [3:0] sys_clock_ctrl;
    logic [3:0] psr;
    logic [3:0] display_drive_mode;
    logic [3:0] lat;
    logic [7:0] tma;
    logic [7:0] tmb;
    logic [13:0] div;
    logic [WDT_W-1:0] wdt;
    logic [15:0] last_ins;
    logic [6:0] mem_addr;
    logic ph_wr;
    logic ph_rd;
    logic [5:0] ph_idx;
    logic rd_ready;
    logic [31:0] hrdata;
  } nbx_state_t;

  nbx_state_t state_q;
  nbx_state_t state_d;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Reads take one wait state so the data word is built from settled state
  always_comb begin
    logic [15:0] ins;
    logic [7:0] op;
    logic [6:0] ra;
    logic [3:0] imm;
    logic [3:0] m;
    logic [3:0] w;
    logic [3:0] res;
    logic [4:0] sum;
    logic [31:0] rd;
    logic exec;
    ins = i_hwdata[15:0];
    op = ins[nbx_pkg::OP_HI:nbx_pkg::OP_LO];
    ra = ins[nbx_pkg::MA_HI:nbx_pkg::MA_LO];
    imm = ins[nbx_pkg::IMM_HI:nbx_pkg::IMM_LO];
    m = state_q.mem[ra];
    w = state_q.mem[{3'h0, ins[nbx_pkg::WR_HI:nbx_pkg::WR_LO]}];
    res = 4'h0;
    sum = 5'h00;
    rd = 32'h0000_0000;
    exec = state_q.ph_wr && (state_q.ph_idx == nbx_pkg::IDX_INSTR) && !state_q.hold && !state_q.stop;
    state_d = state_q;

    // Free-running chains
    state_d.div = state_q.div + 14'h0001;
    state_d.wdt = state_q.wdt + {{(WDT_W-1){1'b0}}, 1'b1};

    // Bus address phase
    if (i_hsel && i_hready && i_htrans == nbx_pkg::HTRANS_NONSEQ) begin
      state_d.ph_wr = i_hwrite;
      state_d.ph_rd = !i_hwrite;
      state_d.ph_idx = i_haddr[7:2];
    end else if (o_hreadyout) begin
      state_d.ph_wr = 1'b0;
      state_d.ph_rd = 1'b0;
    end

    // Read data phase: first cycle stalls and loads the word
    unique case (state_q.ph_idx)
      nbx_pkg::IDX_INSTR: rd = {16'h0000, state_q.last_ins};
      // Watchdog low bits fill the spare field so a restart can be seen
      nbx_pkg::IDX_CORE: rd = {state_q.pc, 2'h0, state_q.sp, state_q.wdt[6:0], state_q.stop, state_q.hold,
                               state_q.ie, state_q.zf, state_q.cy, state_q.acc};
      nbx_pkg::IDX_CTRL: rd = {state_q.psr, state_q.lat, state_q.display_drive_mode, state_q.sys_clock_ctrl,
                               state_q.stop_wake_enables, state_q.hold_release_enables, state_q.event_flags,
                               state_q.param_flags};
      nbx_pkg::IDX_TIMING: rd = {2'h0, state_q.div, state_q.tmb, state_q.tma};
      nbx_pkg::IDX_MEM_ADDR: rd = {25'h0000000, state_q.mem_addr};
      nbx_pkg::IDX_MEM_DATA: rd = {28'h0000000, state_q.mem[state_q.mem_addr]};
      default: rd = 32'h0000_0000;
    endcase
    if (state_q.ph_rd && !state_q.rd_ready) begin
      state_d.hrdata = rd;
      state_d.rd_ready = 1'b1;
    end else begin
      state_d.rd_ready = 1'b0;
    end

    // Plain register writes
    if (state_q.ph_wr && state_q.ph_idx == nbx_pkg::IDX_MEM_ADDR) begin
      state_d.mem_addr = i_hwdata[6:0];
    end
    if (state_q.ph_wr && state_q.ph_idx == nbx_pkg::IDX_MEM_DATA) begin
      state_d.mem[state_q.mem_addr] = i_hwdata[3:0];
    end

    // Instruction execution; unknown codes act as no operation
    if (exec) begin
      state_d.last_ins = ins;
      state_d.pc = state_q.pc + 11'h001;
      if (ins[nbx_pkg::CALL_HI:nbx_pkg::CALL_LO] == nbx_pkg::CALL_CODE) begin
        state_d.stack[state_q.sp] = state_q.pc + 11'h001; // RL20
        state_d.sp = state_q.sp + 3'h1;
        state_d.pc = ins[10:0]; // RL20
      end else begin
        unique case (op)
          nbx_pkg::OP_ADC_M, nbx_pkg::OP_ADC_STORE: begin
            sum = {1'b0, m} + {1'b0, state_q.acc} + {4'h0, state_q.cy}; // RL1
            state_d.acc = sum[3:0];
            state_d.cy = sum[4];
            state_d.zf = (sum[3:0] == 4'h0);
            if (op == nbx_pkg::OP_ADC_STORE) begin
              state_d.mem[ra] = sum[3:0]; // RL3
            end
          end
          nbx_pkg::OP_ADC_I: begin
            sum = {1'b0, w} + {1'b0, imm} + {4'h0, state_q.cy}; // RL2
            state_d.acc = sum[3:0];
            state_d.cy = sum[4];
            state_d.zf = (sum[3:0] == 4'h0);
          end
          nbx_pkg::OP_CY_TO_M: begin
            res = {m[3:1], state_q.cy}; // RL21
            state_d.acc = {state_q.acc[3:1], state_q.cy};
            state_d.mem[ra] = res;
            state_d.zf = ({state_q.acc[3:1], state_q.cy} == 4'h0);
          end
          nbx_pkg::OP_M_TO_CY: state_d.cy = m[0]; // RL21
          nbx_pkg::OP_PARAM_CLR: state_d.param_flags = state_q.param_flags & ~imm; // RL4
          nbx_pkg::OP_PARAM_SET: state_d.param_flags = state_q.param_flags | imm; // RL5
          nbx_pkg::OP_EVENT_CLR: state_d.event_flags = state_q.event_flags & ~imm; // RL6
          nbx_pkg::OP_PORT_EN_LD: state_d.port_enable_flags = imm;
          nbx_pkg::OP_IRQ_EN_LD: state_d.irq_enable_flags = imm;
          nbx_pkg::OP_HOLD_EN_LD: state_d.hold_release_enables = imm; // RL7
          nbx_pkg::OP_WAKE_EN_LD: state_d.stop_wake_enables = imm; // RL8
          nbx_pkg::OP_CLK_CTRL_LD: state_d.sys_clock_ctrl = imm; // RL9
          nbx_pkg::OP_PSR_RD: begin
            state_d.acc = state_q.psr; // RL10
            state_d.mem[ra] = state_q.psr;
            state_d.zf = (state_q.psr == 4'h0);
          end
          nbx_pkg::OP_PSR_CLR: state_d.psr = nbx_pkg::RST_NIB; // RL11
          nbx_pkg::OP_CY_SET: state_d.cy = 1'b1; // RL22
          nbx_pkg::OP_CY_CLR: state_d.cy = 1'b0; // RL22
          nbx_pkg::OP_DIV_CLR: state_d.div = state_q.div & ~{10'h000, nbx_pkg::DIV_LOW_MASK}; // RL12
          nbx_pkg::OP_WDT_CLR: state_d.wdt = '0; // RL24
          nbx_pkg::OP_SHR, nbx_pkg::OP_RRC, nbx_pkg::OP_SHL, nbx_pkg::OP_RLC: begin
            unique case (op)
              nbx_pkg::OP_SHR: begin
                res = {1'b0, m[3:1]}; // RL13
                state_d.cy = m[0];
              end
              nbx_pkg::OP_RRC: begin
                res = {state_q.cy, m[3:1]}; // RL14
                state_d.cy = m[0];
              end
              nbx_pkg::OP_SHL: begin
                res = {m[2:0], 1'b0}; // RL15
                state_d.cy = m[3];
              end
              default: begin
                res = {m[2:0], state_q.cy}; // RL16
                state_d.cy = m[3];
              end
            endcase
            state_d.acc = res;
            state_d.mem[ra] = res;
            state_d.zf = (res == 4'h0);
          end
          nbx_pkg::OP_LAT_I: state_d.lat = imm; // RL24
          nbx_pkg::OP_LAT_RD: state_d.mem[{3'h0, ins[nbx_pkg::WR_HI:nbx_pkg::WR_LO]}] = state_q.lat; // RL24
          nbx_pkg::OP_LAT_WR: state_d.lat = w; // RL24
          nbx_pkg::OP_LAT_ACC: state_d.lat = state_q.acc; // RL24
          nbx_pkg::OP_DRIVE_MODE_LD: state_d.display_drive_mode = imm; // RL17
          nbx_pkg::OP_TMA_H: state_d.tma[7:4] = m; // RL18
          nbx_pkg::OP_TMA_L: state_d.tma[3:0] = m; // RL18
          nbx_pkg::OP_TMB_H: state_d.tmb[7:4] = m; // RL19
          nbx_pkg::OP_TMB_L: state_d.tmb[3:0] = m; // RL19
          nbx_pkg::OP_RET: begin
            state_d.sp = state_q.sp - 3'h1; // RL23
            state_d.pc = state_q.stack[state_q.sp - 3'h1];
          end
          nbx_pkg::OP_HOLD: state_d.hold = 1'b1; // RL23
          nbx_pkg::OP_STOP: state_d.stop = 1'b1; // RL23
          nbx_pkg::OP_INT_EN: state_d.ie = 1'b1; // RL22
          nbx_pkg::OP_INT_DIS: state_d.ie = 1'b0; // RL22
          default: state_d.pc = state_q.pc + 11'h001;
        endcase
      end
    end

    // Hardware sets win over a same-cycle clear
    state_d.event_flags = state_d.event_flags | i_event_set;
    state_d.psr = state_d.psr | i_port_status_set;

    // Leave power-down only through an enabled source
    if (state_q.hold && |(i_hold_release_src & state_q.hold_release_enables)) begin
      state_d.hold = 1'b0;
    end
    if (state_q.stop && |(i_wake_pins & state_q.stop_wake_enables)) begin
      state_d.stop = 1'b0;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Whole state resets to constants; memory clears too, costing reset area
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Ready drops only in the first cycle of a read data phase
  assign o_hreadyout = !(state_q.ph_rd && !state_q.rd_ready);
  assign o_hresp = nbx_pkg::HRESP_OKAY;
  assign o_hrdata = state_q.hrdata;
  assign o_hold = state_q.hold;
  assign o_stop = state_q.stop;
  assign o_int_en = state_q.ie;
  assign o_param_flags = state_q.param_flags;
  assign o_event_flags = state_q.event_flags;
  assign o_port_enables = state_q.port_enable_flags;
  assign o_irq_enables = state_q.irq_enable_flags;
  assign o_sys_clock_ctrl = state_q.sys_clock_ctrl;
  assign o_display_mode = state_q.display_drive_mode;
  assign o_display_latch = state_q.lat;
  assign o_timer_a_preset = state_q.tma;
  assign o_timer_b_preset = state_q.tmb;
  assign o_pc = state_q.pc;

endmodule

`default_nettype wire

// *** dv/nbx_exec_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Port checker of the nibble execute unit
// ****************************************************************
module nbx_exec_properties (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic [1:0] o_hresp,
  input wire logic [3:0] i_event_set,
  input wire logic o_hold,
  input wire logic o_stop,
  input wire logic o_int_en,
  input wire logic [3:0] o_param_flags,
  input wire logic [3:0] o_event_flags,
  input wire logic [3:0] o_sys_clock_ctrl,
  input wire logic [7:0] o_timer_a_preset,
  input wire logic [10:0] o_pc
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  logic wr_q;
  logic ex_q;
  logic [15:0] op_q;
  wire logic tk = i_hsel && i_hready && i_htrans == nbx_pkg::HTRANS_NONSEQ;
  wire logic [7:0] op = op_q[15:8];
  // Flags an instruction write; ex_q is high in the cycle after it took effect
  // and stays low for writes refused while powered down
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wr_q <= 1'b0;
      ex_q <= 1'b0;
      op_q <= 16'h0000;
    end else begin
      wr_q <= tk && i_hwrite && i_haddr[7:2] == nbx_pkg::IDX_INSTR;
      ex_q <= wr_q && !o_hold && !o_stop;
      op_q <= i_hwdata[15:0];
    end
  end
  // ****************************************************************
  // Properties
  // ****************************************************************
  AST_RESP_OKAY: assert property (o_hresp == nbx_pkg::HRESP_OKAY)
    else $error("response not okay");
  AST_READ_WAIT: assert property (tk && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
    else $error("read data phase length wrong");
  AST_WRITE_NOWAIT: assert property (tk && i_hwrite |=> o_hreadyout)
    else $error("write data phase stalled");
  AST_PARAM_SET: assert property (ex_q && op == nbx_pkg::OP_PARAM_SET |->
    o_param_flags == ($past(o_param_flags) | op_q[7:4])) else $error("param set wrong");
  AST_PARAM_CLR: assert property (ex_q && op == nbx_pkg::OP_PARAM_CLR |->
    o_param_flags == ($past(o_param_flags) & ~op_q[7:4])) else $error("param clear wrong");
  AST_EVENT_SET: assert property (i_event_set != 4'h0 |=>
    (o_event_flags & $past(i_event_set)) == $past(i_event_set)) else $error("event set lost");
  AST_CLK_CTRL_LD: assert property (ex_q && op == nbx_pkg::OP_CLK_CTRL_LD |-> o_sys_clock_ctrl == op_q[7:4])
    else $error("clock control load wrong");
  AST_CALL: assert property (ex_q && op_q[15:11] == nbx_pkg::CALL_CODE |-> o_pc == op_q[10:0])
    else $error("call target wrong");
  AST_PC_ONLY_EXEC: assert property (!$stable(o_pc) |-> ex_q)
    else $error("pc moved without instruction");
  AST_HOLD_ENTRY: assert property (ex_q && op == nbx_pkg::OP_HOLD |-> o_hold)
    else $error("hold not entered");
  AST_TIMER_A: assert property (!$stable(o_timer_a_preset) |-> ex_q &&
    (op == nbx_pkg::OP_TMA_H || op == nbx_pkg::OP_TMA_L)) else $error("timer preset moved");
  AST_INT_EN: assert property (ex_q && op == nbx_pkg::OP_INT_EN |-> o_int_en)
    else $error("interrupt enable not set");
endmodule
bind nbx_exec nbx_exec_properties u_props (.i_mclk(i_mclk), .i_rst(i_rst), .i_hsel(i_hsel),
  .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_event_set(i_event_set), .o_hold(o_hold),
  .o_stop(o_stop), .o_int_en(o_int_en), .o_param_flags(o_param_flags), .o_event_flags(o_event_flags),
  .o_sys_clock_ctrl(o_sys_clock_ctrl), .o_timer_a_preset(o_timer_a_preset), .o_pc(o_pc));
`default_nettype wire

// *** dv/nbx_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
  logic [3:0] evs = 4'h0, pss = 4'h0, hrs = 4'h0, wks = 4'h0, r, c;
  wire logic rdy, hold, stop, ie;
  wire logic [1:0] resp;
  wire logic [31:0] rdata;
  wire logic [3:0] pflags, eflags, port_en, irq_en, clk_ctrl, dmode, lat;
  wire logic [7:0] tma, tmb;
  wire logic [10:0] pc;
  int errors = 0, checked = 0;
  nbx_exec uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(rdy), .o_hreadyout(rdy),
    .o_hresp(resp), .o_hrdata(rdata), .i_event_set(evs), .i_port_status_set(pss),
    .i_hold_release_src(hrs), .i_wake_pins(wks), .o_hold(hold), .o_stop(stop), .o_int_en(ie),
    .o_param_flags(pflags), .o_event_flags(eflags), .o_port_enables(port_en), .o_irq_enables(irq_en),
    .o_sys_clock_ctrl(clk_ctrl), .o_display_mode(dmode), .o_display_latch(lat),
    .o_timer_a_preset(tma), .o_timer_b_preset(tmb), .o_pc(pc));
  // Free-running 25 MHz clock
  always #20 i_mclk = ~i_mclk;
  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic finish_test();
    if (errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait for ready; a hung slave ends the run
  task automatic wt();
    int n;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (rdy !== 1'b1 && n < 64);
    if (rdy !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: bus wait timed out", $time);
      finish_test();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= nbx_pkg::HTRANS_NONSEQ;
    wt();
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    q = rdata;
  endtask
  task automatic ex(input logic [7:0] op, input logic [7:0] lo);
    bus(1'b1, 8'h00, {16'h0, op, lo});
  endtask
  task automatic ms(input logic [7:0] a, input logic [3:0] v);
    bus(1'b1, 8'h10, {24'h0, a});
    bus(1'b1, 8'h14, {28'h0, v});
  endtask
  task automatic mck(input logic [7:0] a, input logic [3:0] v);
    bus(1'b1, 8'h10, {24'h0, a});
    bus(1'b0, 8'h14, 32'h0);
    ck(q[3:0], v);
  endtask
  // Zero, carry and result nibble from the core status word
  task automatic cc(input logic z, input logic y, input logic [3:0] a);
    bus(1'b0, 8'h04, 32'h0);
    ck(q[5:0], {z, y, a});
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    bus(1'b0, 8'h08, 32'h0);
    ck(q, 32'h0);
    bus(1'b0, 8'h40, 32'h0);
    ck(q, 32'h0);
    ex(nbx_pkg::OP_CY_SET, 8'h00);
    ms(8'h20, 4'h9);
    ex(nbx_pkg::OP_ADC_M, 8'h20);
    cc(1'b0, 1'b0, 4'ha);
    ex(nbx_pkg::OP_ADC_M, 8'h20);
    cc(1'b0, 1'b1, 4'h3);
    mck(8'h20, 4'h9);
    ms(8'h05, 4'h7);
    ex(nbx_pkg::OP_ADC_I, 8'h85);
    cc(1'b1, 1'b1, 4'h0);
    mck(8'h05, 4'h7);
    ms(8'h21, 4'h6);
    ex(nbx_pkg::OP_ADC_STORE, 8'h21);
    cc(1'b0, 1'b0, 4'h7);
    mck(8'h21, 4'h7);
    // Each shift form with both carry values; zero results show up twice
    for (int i = 0; i < 8; i++) begin
      c = i[0] ? 4'h9 : 4'h1;
      ms(8'h30, c);
      ex(i[0] ? nbx_pkg::OP_CY_SET : nbx_pkg::OP_CY_CLR, 8'h00);
      ex(nbx_pkg::OP_SHR + 8'(i >> 1), 8'h30);
      case (i >> 1)
        0: r = {1'b0, c[3:1]};
        1: r = {i[0], c[3:1]};
        2: r = {c[2:0], 1'b0};
        default: r = {c[2:0], i[0]};
      endcase
      cc(r == 4'h0, (i < 4) ? c[0] : c[3], r);
      mck(8'h30, r);
    end
    ex(nbx_pkg::OP_CY_CLR, 8'h00);
    ms(8'h31, 4'hf);
    ex(nbx_pkg::OP_CY_TO_M, 8'h31);
    cc(1'b0, 1'b0, 4'h2);
    mck(8'h31, 4'he);
    ms(8'h32, 4'h1);
    ex(nbx_pkg::OP_M_TO_CY, 8'h32);
    cc(1'b0, 1'b1, 4'h2);
    ex(nbx_pkg::OP_PARAM_SET, 8'hb0);
    ex(nbx_pkg::OP_PARAM_CLR, 8'h30);
    evs <= 4'h6;
    @(posedge i_mclk);
    evs <= 4'h0;
    ex(nbx_pkg::OP_EVENT_CLR, 8'h20);
    ex(nbx_pkg::OP_HOLD_EN_LD, 8'h50);
    ex(nbx_pkg::OP_WAKE_EN_LD, 8'ha0);
    ex(nbx_pkg::OP_CLK_CTRL_LD, 8'h30);
    ex(nbx_pkg::OP_DRIVE_MODE_LD, 8'hc0);
    ex(nbx_pkg::OP_PORT_EN_LD, 8'h90);
    ex(nbx_pkg::OP_IRQ_EN_LD, 8'h60);
    pss <= 4'h5;
    ex(nbx_pkg::OP_INT_EN, 8'h00);
    pss <= 4'h0;
    bus(1'b0, 8'h08, 32'h0);
    ck(q, 32'h50c3a548);
    ck({port_en, irq_en, 3'h0, ie}, 12'h961);
    ck({pflags, eflags, clk_ctrl, dmode, resp}, 18'h210f0);
    ex(nbx_pkg::OP_PSR_RD, 8'h33);
    cc(1'b0, 1'b1, 4'h5);
    mck(8'h33, 4'h5);
    ex(nbx_pkg::OP_PSR_CLR, 8'h00);
    ex(nbx_pkg::OP_PSR_RD, 8'h34);
    cc(1'b1, 1'b1, 4'h0);
    ms(8'h35, 4'hc);
    ex(nbx_pkg::OP_TMA_H, 8'h35);
    ex(nbx_pkg::OP_TMB_L, 8'h35);
    ms(8'h35, 4'h3);
    ex(nbx_pkg::OP_TMA_L, 8'h35);
    ex(nbx_pkg::OP_TMB_H, 8'h35);
    @(posedge i_mclk);
    ck({tma, tmb}, 16'hc33c);
    // A cleared nibble has counted once when the read word is built
    ex(nbx_pkg::OP_DIV_CLR, 8'h00);
    bus(1'b0, 8'h0c, 32'h0);
    ck(q[19:0], 20'h13cc3);
    ex(nbx_pkg::OP_WDT_CLR, 8'h00);
    bus(1'b0, 8'h04, 32'h0);
    ck(q[15:9], 7'h01);
    bus(1'b0, 8'h00, 32'h0);
    ck(q, 32'h00004f00);
    ex(nbx_pkg::OP_LAT_I, 8'h90);
    ex(nbx_pkg::OP_LAT_RD, 8'h02);
    mck(8'h02, 4'h9);
    ex(nbx_pkg::OP_LAT_ACC, 8'h00);
    @(posedge i_mclk);
    ck(lat, 4'h0);
    ex(nbx_pkg::OP_LAT_WR, 8'h05);
    @(posedge i_mclk);
    ck(lat, 4'h7);
    ex({nbx_pkg::CALL_CODE, 3'h7}, 8'hfe);
    ex({nbx_pkg::CALL_CODE, 3'h1}, 8'h23);
    @(posedge i_mclk);
    ck(pc, 11'h123);
    ex(nbx_pkg::OP_RET, 8'h00);
    @(posedge i_mclk);
    ck(pc, 11'h7ff);
    // Instruction writes during hold are refused, so pc stays at the wrapped value
    ex(nbx_pkg::OP_HOLD, 8'h00);
    ex(nbx_pkg::OP_NOP, 8'h00);
    hrs <= 4'h2;
    repeat (3) @(posedge i_mclk);
    ck({hold, pc}, {1'b1, 11'h000});
    hrs <= 4'h4;
    repeat (2) @(posedge i_mclk);
    ck(hold, 1'b0);
    hrs <= 4'h0;
    ex(nbx_pkg::OP_STOP, 8'h00);
    wks <= 4'h1;
    repeat (3) @(posedge i_mclk);
    ck(stop, 1'b1);
    wks <= 4'h8;
    repeat (2) @(posedge i_mclk);
    ck(stop, 1'b0);
    wks <= 4'h0;
    ex(nbx_pkg::OP_INT_DIS, 8'h00);
    @(posedge i_mclk);
    ck(ie, 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
